/* File: hw/icsr_scan_readout.sv */
// Channel sequencer and register file of the inductive scan readout block.
//
// Contract
// - In scan mode convert channels one at a time, only one active.
// - Ground both sensor pins of every channel not currently active.
// - Scan disabled: convert continuously on channel chosen by setup bits 15:14.
// - Scan enabled: convert continuously across channels in scan order.
// - Scan order 00: ch0,1; 01: ch0,1,2; 10: ch0,1,2,3.
// - Scan order 11 behaves like 00, channels 0 and 1.
// - One conversion per listed channel, then restart list, forever.
// - Result bits 11:0 are top twelve bits of 16-bit measurement.
// - Under-range reports all zeros, over-range reports all ones.
// - Divider 1, offset 0: result equals sensor freq times 4096 over ref.
// - Subtract a per-channel 16-bit offset word from each raw measurement.
`timescale 1ns/10ps
module icsr_scan_readout #(
  parameter int NUM_CH = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        conv_done_i,
  input  wire logic [15:0] conv_meas_i,
  output logic             conv_start_o,
  output logic      [1:0]  active_ch_o,
  output logic      [3:0]  pin_a_gnd_o,
  output logic      [3:0]  pin_b_gnd_o
);

  icsr_pkg::icsr_state_t state_q;
  logic [15:0]           device_setup_q;
  logic [15:0]           scan_setup_q;
  logic [15:0]           offset_q [NUM_CH];
  logic [1:0]            ch_q;
  logic [1:0]            ch_d;
  logic [1:0]            last_ch;
  logic                  scan_en;
  logic [15:0]           meas_q;
  logic [NUM_CH-1:0]     load;
  logic [11:0]           res_word [NUM_CH];
  logic [NUM_CH-1:0]     res_under;
  logic [NUM_CH-1:0]     res_over;

  assign scan_en = scan_setup_q[icsr_pkg::SCAN_ENABLE_BIT];

  // ==========================================================================
  // Scan list decode
  // ==========================================================================
  always_comb
  begin
    case (icsr_pkg::icsr_order_t'(scan_setup_q[icsr_pkg::SCAN_ORDER_HI:
                                               icsr_pkg::SCAN_ORDER_LO]))
      icsr_pkg::ICSR_ORDER_2CH:     last_ch = 2'h1;
      icsr_pkg::ICSR_ORDER_3CH:     last_ch = 2'h2;
      icsr_pkg::ICSR_ORDER_4CH:     last_ch = 2'h3;
      icsr_pkg::ICSR_ORDER_2CH_ALT: last_ch = 2'h1;
      default:                      last_ch = 2'h1;
    endcase
  end

  // Next channel after a finished conversion.
  always_comb
  begin
    if (!scan_en)
    begin
      ch_d = device_setup_q[icsr_pkg::CHAN_SEL_HI:icsr_pkg::CHAN_SEL_LO];
    end
    else if (ch_q >= last_ch)
    begin
      ch_d = 2'h0;
    end
    else
    begin
      ch_d = ch_q + 2'h1;
    end
  end

  // ==========================================================================
  // Sequencer: one channel converts at a time
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_q      <= icsr_pkg::ICSR_ST_IDLE;
      ch_q         <= 2'h0;
      meas_q       <= 16'h0000;
      conv_start_o <= 1'b0;
    end
    else
    begin
      conv_start_o <= 1'b0;
      case (state_q)
        icsr_pkg::ICSR_ST_IDLE:
        begin
          ch_q         <= ch_d;
          conv_start_o <= 1'b1;
          state_q      <= icsr_pkg::ICSR_ST_CONVERT;
        end
        icsr_pkg::ICSR_ST_CONVERT:
        begin
          if (conv_done_i)
          begin
            meas_q  <= conv_meas_i;
            state_q <= icsr_pkg::ICSR_ST_STORE;
          end
        end
        icsr_pkg::ICSR_ST_STORE:
        begin
          state_q <= icsr_pkg::ICSR_ST_IDLE;
        end
        default:
        begin
          state_q <= icsr_pkg::ICSR_ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Active channel and sensor pin grounding
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      active_ch_o <= 2'h0;
      pin_a_gnd_o <= 4'hf;
      pin_b_gnd_o <= 4'hf;
    end
    else
    begin
      // The start pulse and the channel it names leave on the same edge.
      if (state_q == icsr_pkg::ICSR_ST_IDLE)
      begin
        active_ch_o <= ch_d;
      end
      else
      begin
        active_ch_o <= ch_q;
      end
      for (int i = 0; i < 4; i++)
      begin
        pin_a_gnd_o[i] <= !((state_q == icsr_pkg::ICSR_ST_CONVERT) &&
                            (ch_q == 2'(i)));
        pin_b_gnd_o[i] <= !((state_q == icsr_pkg::ICSR_ST_CONVERT) &&
                            (ch_q == 2'(i)));
      end
    end
  end

  // ==========================================================================
  // Result slots
  // ==========================================================================
  for (genvar g = 0; g < NUM_CH; g++)
  begin : g_slot
    icsr_result_if rif ();
    assign load[g]             = (state_q == icsr_pkg::ICSR_ST_STORE) &&
                                 (ch_q == 2'(g));
    assign rif.load            = load[g];
    assign rif.measurement     = meas_q;
    assign rif.offset_word     = offset_q[g];
    assign res_word[g]         = rif.result_word;
    assign res_under[g]        = rif.under_range;
    assign res_over[g]         = rif.over_range;
    icsr_result_slot u_slot (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .rif     (rif)
    );
  end

  // ==========================================================================
  // Register writes
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      device_setup_q <= icsr_pkg::DEVICE_SETUP_RESET;
      scan_setup_q   <= icsr_pkg::SCAN_SETUP_RESET;
      for (int i = 0; i < NUM_CH; i++)
      begin
        offset_q[i] <= icsr_pkg::OFFSET_RESET;
      end
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == icsr_pkg::ADDR_DEVICE_SETUP)
      begin
        device_setup_q <= reg_wdata_i;
      end
      if (reg_addr_i == icsr_pkg::ADDR_SCAN_SETUP)
      begin
        scan_setup_q <= reg_wdata_i;
      end
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (reg_addr_i == icsr_pkg::ADDR_FREQ_OFFSET_CH0 + 8'(i))
        begin
          offset_q[i] <= reg_wdata_i;
        end
      end
    end
  end

  // ==========================================================================
  // Register reads: data registered one cycle after the read strobe
  // ==========================================================================
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      reg_rdata_o <= 16'h0000;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= 16'h0000;
      if (reg_addr_i == icsr_pkg::ADDR_DEVICE_SETUP)
      begin
        reg_rdata_o <= device_setup_q;
      end
      if (reg_addr_i == icsr_pkg::ADDR_SCAN_SETUP)
      begin
        reg_rdata_o <= scan_setup_q;
      end
      for (int i = 0; i < NUM_CH; i++)
      begin
        if (reg_addr_i == icsr_pkg::ADDR_RESULT_CH0 + 8'(2 * i))
        begin
          reg_rdata_o <= {4'h0, res_word[i]};
        end
        if (reg_addr_i == icsr_pkg::ADDR_FREQ_OFFSET_CH0 + 8'(i))
        begin
          reg_rdata_o <= offset_q[i];
        end
      end
    end
  end

endmodule : icsr_scan_readout

/* File: common/icsr_pkg.sv */
// Constants and types for the inductive channel scan readout block.
package icsr_pkg;

  // ==========================================================================
  // Register map (offsets are register indices on the register port)
  // ==========================================================================
  localparam logic [7:0] ADDR_RESULT_CH0       = 8'h00;
  localparam logic [7:0] ADDR_RESULT_CH1       = 8'h02;
  localparam logic [7:0] ADDR_RESULT_CH2       = 8'h04;
  localparam logic [7:0] ADDR_RESULT_CH3       = 8'h06;
  localparam logic [7:0] ADDR_FREQ_OFFSET_CH0  = 8'h0c;
  localparam logic [7:0] ADDR_FREQ_OFFSET_CH1  = 8'h0d;
  localparam logic [7:0] ADDR_FREQ_OFFSET_CH2  = 8'h0e;
  localparam logic [7:0] ADDR_FREQ_OFFSET_CH3  = 8'h0f;
  localparam logic [7:0] ADDR_DEVICE_SETUP     = 8'h1a;
  localparam logic [7:0] ADDR_SCAN_SETUP       = 8'h1b;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int          CHAN_SEL_HI          = 15;
  localparam int          CHAN_SEL_LO          = 14;
  localparam int          SCAN_ENABLE_BIT      = 15;
  localparam int          SCAN_ORDER_HI        = 14;
  localparam int          SCAN_ORDER_LO        = 13;
  localparam int          MEAS_TOP_BIT         = 15;
  localparam int          MEAS_SEL_LO          = 4;
  localparam logic [15:0] DEVICE_SETUP_RESET   = 16'h0001;
  localparam logic [15:0] SCAN_SETUP_RESET     = 16'h020f;
  localparam logic [15:0] OFFSET_RESET         = 16'h0000;
  localparam logic [11:0] CODE_UNDER_RANGE     = 12'h000;
  localparam logic [11:0] CODE_OVER_RANGE      = 12'hfff;

  // ==========================================================================
  // Scan order codes
  // ==========================================================================
  typedef enum logic [1:0] {
    ICSR_ORDER_2CH     = 2'b00,
    ICSR_ORDER_3CH     = 2'b01,
    ICSR_ORDER_4CH     = 2'b10,
    ICSR_ORDER_2CH_ALT = 2'b11
  } icsr_order_t;

  // ==========================================================================
  // Sequencer states (Gray coded along the measure path)
  // ==========================================================================
  typedef enum logic [1:0] {
    ICSR_ST_IDLE    = 2'b00,
    ICSR_ST_CONVERT = 2'b01,
    ICSR_ST_STORE   = 2'b11
  } icsr_state_t;

endpackage : icsr_pkg

/* File: common/icsr_result_if.sv */
// Carrier between the sequencer and the per-channel result slot.
`timescale 1ns/10ps
interface icsr_result_if;
  logic        load;
  logic [15:0] measurement;
  logic [15:0] offset_word;
  logic [11:0] result_word;
  logic        under_range;
  logic        over_range;

  modport seq  (output load, output measurement, output offset_word,
                input result_word, input under_range, input over_range);
  modport slot (input load, input measurement, input offset_word,
                output result_word, output under_range, output over_range);
endinterface : icsr_result_if

/* File: hw/icsr_result_slot.sv */
// One channel's result word: offset subtraction, range codes, hold register.
`timescale 1ns/10ps
module icsr_result_slot (
  input  wire logic  clk_i,
  input  wire logic  rst_n_i,
  icsr_result_if.slot rif
);

  logic [16:0] diff;
  logic [11:0] result_q;
  logic        under_q;
  logic        over_q;
  logic [11:0] code_d;

  // ==========================================================================
  // Offset subtraction on the full measurement, then top twelve bits
  // ==========================================================================
  always_comb
  begin
    diff = {1'b0, rif.measurement} - {1'b0, rif.offset_word};
    if (diff[16])
    begin
      code_d = icsr_pkg::CODE_UNDER_RANGE;
    end
    else
    begin
      code_d = diff[icsr_pkg::MEAS_TOP_BIT:icsr_pkg::MEAS_SEL_LO];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      result_q <= 12'h000;
      under_q  <= 1'b0;
      over_q   <= 1'b0;
    end
    else if (rif.load)
    begin
      result_q <= code_d;
      under_q  <= (code_d == icsr_pkg::CODE_UNDER_RANGE);
      over_q   <= (code_d == icsr_pkg::CODE_OVER_RANGE);
    end
  end

  assign rif.result_word = result_q;
  assign rif.under_range = under_q;
  assign rif.over_range  = over_q;

endmodule : icsr_result_slot

/* File: dv/icsr_sr_assertions.sv */
// Port checker for the inductive channel scan readout block.
`timescale 1ns/10ps
module icsr_sr_assertions (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_rdata_o,
  input  wire logic        conv_done_i,
  input  wire logic        conv_start_o,
  input  wire logic [1:0]  active_ch_o,
  input  wire logic [3:0]  pin_a_gnd_o,
  input  wire logic [3:0]  pin_b_gnd_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ====================
  // Assertions
  chk_pins_paired: assert property (pin_a_gnd_o == pin_b_gnd_o)
    else $error("sensor pin grounds differ");
  chk_one_active: assert property ($countones(pin_a_gnd_o) >= 3)
    else $error("more than one channel active");
  chk_active_released: assert property (conv_start_o |=>
    !pin_a_gnd_o[active_ch_o]) else $error("active channel grounded");
  chk_chan_held: assert property (conv_start_o |=> $stable(active_ch_o))
    else $error("channel changed during conversion");
  chk_start_spacing: assert property (conv_start_o |=> !conv_start_o [*2])
    else $error("start too soon after start");
  chk_scan_restart: assert property (conv_done_i |-> ##[1:4] conv_start_o)
    else $error("no new conversion after done");
  chk_reset_state: assert property (disable iff (1'b0) !rst_n_i |=>
    (pin_a_gnd_o == 4'hf && !conv_start_o && reg_rdata_o == 16'h0000))
    else $error("outputs not at reset state");
  chk_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without read");
  cov_ch3: cover property (conv_start_o && active_ch_o == 2'd3);
  cov_done: cover property (conv_done_i);
  cov_read: cover property (reg_rd_i);
endmodule : icsr_sr_assertions

bind icsr_scan_readout icsr_sr_assertions u_chk (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .conv_done_i(conv_done_i), .conv_start_o(conv_start_o),
  .active_ch_o(active_ch_o), .pin_a_gnd_o(pin_a_gnd_o),
  .pin_b_gnd_o(pin_b_gnd_o));

/* File: dv/icsr_sensor_model.sv */
// Behavioural sensor coil and oscillator counter for each channel.
`timescale 1ns/10ps
module icsr_sensor_model (
  input  wire logic             clk_i,
  input  wire logic             start_i,
  input  wire logic [1:0]       ch_i,
  input  wire logic [3:0][15:0] meas_i,
  input  wire logic [3:0]       wait_i,
  output logic                  done_o,
  output logic      [15:0]      meas_o
);
  logic       busy_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [1:0] ch_q = 2'h0;
  initial done_o = 1'b0;
  initial meas_o = 16'h0000;
  // ====================
  // Measurement is only valid with done; it toggles otherwise.
  always @(posedge clk_i)
  begin
    done_o <= 1'b0;
    meas_o <= ~meas_o;
    if (start_i)
    begin
      busy_q <= 1'b1;
      cnt_q  <= wait_i;
      ch_q   <= ch_i;
    end
    else if (busy_q && cnt_q == 4'h0)
    begin
      busy_q <= 1'b0;
      done_o <= 1'b1;
      meas_o <= meas_i[ch_q];
    end
    else if (busy_q)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule : icsr_sensor_model

/* File: dv/tb.sv */
// Self-checking testbench for the inductive channel scan readout block.
`timescale 1ns/10ps
`define CHK(a, b) \
  begin \
    check_count++; \
    if ((a) !== (b)) \
      $display("[ERR] %0t got %h exp %h", $time, (a), (b)); \
    if ((a) !== (b)) \
      n_errors++; \
  end
module tb;
  logic             clk_i = 1'b0;
  logic             rst_n_i = 1'b0;
  logic [7:0]       reg_addr_i = 8'h00;
  logic             reg_wr_i = 1'b0;
  logic             reg_rd_i = 1'b0;
  logic [15:0]      reg_wdata_i = 16'h0000;
  logic [15:0]      reg_rdata_o;
  logic             conv_done_i;
  logic [15:0]      conv_meas_i;
  logic             conv_start_o;
  logic [1:0]       active_ch_o;
  logic [3:0]       pin_a_gnd_o;
  logic [3:0]       pin_b_gnd_o;
  logic [3:0]       wait_q = 4'h5;
  logic [3:0][15:0] meas = {16'hffff, 16'h0010, 16'h1203, 16'h7a35};
  logic [3:0][15:0] offs = {16'h0000, 16'h0020, 16'h0004, 16'h0000};
  logic [1:0]       seq_q[$];
  int               n_errors = 0;
  int               check_count = 0;
  int               cyc = 0;
  always #12.5 clk_i = ~clk_i;
  icsr_scan_readout u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .conv_done_i(conv_done_i), .conv_meas_i(conv_meas_i),
    .conv_start_o(conv_start_o), .active_ch_o(active_ch_o),
    .pin_a_gnd_o(pin_a_gnd_o), .pin_b_gnd_o(pin_b_gnd_o));
  icsr_sensor_model u_sensor (.clk_i(clk_i), .start_i(conv_start_o),
    .ch_i(active_ch_o), .meas_i(meas), .wait_i(wait_q),
    .done_o(conv_done_i), .meas_o(conv_meas_i));
  // ====================
  // Register port tasks and helpers.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr_i  = a;
    reg_wdata_i = d;
    reg_wr_i    = 1'b1;
    @(posedge clk_i) #1 reg_wr_i = 1'b0;
    @(posedge clk_i) #1;
  endtask : wr
  task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
    reg_addr_i = a;
    reg_rd_i   = 1'b1;
    @(posedge clk_i) #1 reg_rd_i = 1'b0;
    @(posedge clk_i) #1;
    `CHK(reg_rdata_o, e)
  endtask : chk_rd
  task automatic collect(input int n);
    seq_q.delete();
    for (int i = 0; i < 400 && seq_q.size() < n; i++)
      @(posedge clk_i) #1;
  endtask : collect
  function automatic logic [15:0] exp_res(input logic [15:0] m, o);
    logic [15:0] d;
    d = m - o;
    return (m < o) ? 16'h0000 : {4'h0, d[15:4]};
  endfunction : exp_res
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_i)
  begin
    if (conv_start_o === 1'b1)
      seq_q.push_back(active_ch_o);
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    int k;
    int n;
    repeat (8) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk_rd(icsr_pkg::ADDR_SCAN_SETUP, 16'h020f);
    chk_rd(8'h1f, 16'h0000);
    for (int c = 0; c < 4; c++)
      wr(8'h0c + 8'(c), offs[c]);
    for (int c = 0; c < 4; c++)
      chk_rd(8'h0c + 8'(c), offs[c]);
    $display("registers test done");
    for (int c = 0; c < 4; c++)
    begin
      wr(icsr_pkg::ADDR_DEVICE_SETUP, {c[1:0], 14'h0001});
      collect(2);
      collect(3);
      `CHK(seq_q.size(), 3)
      foreach (seq_q[i])
        `CHK(seq_q[i], c[1:0])
      chk_rd(8'(2 * c), exp_res(meas[c], offs[c]));
    end
    wr(icsr_pkg::ADDR_RESULT_CH0, 16'h5555);
    chk_rd(icsr_pkg::ADDR_RESULT_CH0, 16'h07a3);
    $display("single channel test done");
    wait_q = 4'h0;
    for (int o = 0; o < 4; o++)
    begin
      n = (o == 2) ? 4 : (o == 1) ? 3 : 2;
      wr(icsr_pkg::ADDR_SCAN_SETUP, {1'b1, o[1:0], 13'h020f});
      collect(6);
      k = 0;
      collect(1);
      while (seq_q[0] !== 2'd0 && k++ < 8)
        collect(1);
      collect(2 * n);
      `CHK(seq_q.size(), 2 * n)
      foreach (seq_q[i])
        `CHK(seq_q[i], 2'((i + 1) % n))
    end
    $display("scan test done");
    rst_n_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    chk_rd(icsr_pkg::ADDR_SCAN_SETUP, 16'h020f);
    chk_rd(icsr_pkg::ADDR_FREQ_OFFSET_CH1, 16'h0000);
    chk_rd(icsr_pkg::ADDR_RESULT_CH1, 16'h0000);
    $display("reset test done");
    tally_and_finish();
  end
endmodule : tb
